//--- shared/masd_pkg.sv
// shared constants and types for the memory address space decoder
package masd_pkg;

  // program space
  localparam int PROG_LOCATIONS = 4194304;
  localparam int PROG_ADDR_W = 24;
  localparam int IP_W = 23;
  localparam logic [22:0] IP_STEP = 23'h000002;
  localparam logic [22:0] IP_RESET = 23'h000000;
  localparam logic [23:0] RESET_VECTOR = 24'h000000;
  localparam logic [23:0] JUMP_TARGET_ADDR = 24'h000002;
  localparam logic [23:0] IVT_START = 24'h000004;
  localparam logic [23:0] IVT_END = 24'h0000ff;
  localparam logic [23:0] ALT_IVT_START = 24'h000100;
  localparam logic [23:0] ALT_IVT_END = 24'h0001ff;
  localparam logic [23:0] VECTOR_END = 24'h000200;
  localparam logic [23:0] USER_TOP = 24'h7fffff;
  localparam logic [23:0] FLASH_END = 24'h02ac00;
  localparam logic [23:0] CONFIG_START = 24'hf80000;
  localparam logic [23:0] CONFIG_END = 24'hf80017;
  localparam logic [23:0] IDENT_START = 24'hff0000;
  localparam int UPPER_HALF_BIT = 23;
  localparam int TABLE_PAGE_UPPER_BIT = 7;

  // data space
  localparam int DATA_ADDR_W = 16;
  localparam int RAM_BYTES = 16384;
  localparam logic [15:0] RAM_TOP = 16'h3fff;
  localparam int RAM_INDEX_W = 13;
  localparam int WINDOW_SELECT_BIT = 15;
  localparam int CORE_WINDOW_ENABLE_BIT = 2;
  localparam logic [1:0] LANES_WORD = 2'h3;
  localparam logic [1:0] LANES_LOW = 2'h1;
  localparam logic [1:0] LANES_HIGH = 2'h2;

  typedef enum logic [2:0] {
    region_reset_vector,
    region_primary_vectors,
    region_alternate_vectors,
    region_user_flash,
    region_unimplemented,
    region_config,
    region_reserved
  } masd_region_type;

  typedef struct packed {
    logic [22:0] ip;
    logic [23:0] fetch_addr;
    masd_region_type fetch_region;
    logic ram_rd_en;
    logic [12:0] ram_rd_index;
    logic ram_wr_en;
    logic [12:0] ram_wr_index;
    logic [1:0] ram_wr_lanes;
    logic [15:0] ram_wr_data;
    logic flash_rd_en;
    logic flash_wr_en;
    logic [23:0] flash_addr;
    logic [15:0] flash_wr_data;
    masd_region_type flash_region;
    logic rd_pend;
    logic rd_zero;
    logic rd_hi;
    logic rd_byte;
    logic rd_win;
    logic tbl_pend;
    logic tbl_hi;
    logic tbl_zero;
    logic [15:0] rd_data;
    logic rd_valid;
    logic [15:0] table_data;
    logic table_valid;
    logic addr_error;
  } masd_state_type;

endpackage

//--- logic/masd_data_decode.sv
// one data-space address generator decode: range, window routing, alignment, lanes
module masd_data_decode (
  input wire logic [15:0] byte_addr,
  input wire logic word_access,
  input wire logic window_enable,
  output logic in_ram,
  output logic to_window,
  output logic misaligned,
  output logic [12:0] word_index,
  output logic [1:0] lanes
);

  logic lower_half;

  assign lower_half = ~byte_addr[masd_pkg::WINDOW_SELECT_BIT];
  // anything past the implemented ram in the lower half decodes to nothing
  assign in_ram = lower_half && (byte_addr <= masd_pkg::RAM_TOP);
  assign to_window = byte_addr[masd_pkg::WINDOW_SELECT_BIT] && window_enable;
  assign misaligned = word_access && byte_addr[0];
  // shared word decode, byte picked by the low address bit
  assign word_index = byte_addr[13:1];
  assign lanes = word_access ? masd_pkg::LANES_WORD :
                 (byte_addr[0] ? masd_pkg::LANES_HIGH : masd_pkg::LANES_LOW);

endmodule

//--- logic/masd_top.sv
// program and data address space decoder for the cpu core

// Overview of operation
// - program space holds 4M instruction locations.
// - program addresses are 24 bits, from 23-bit pointer or table/window paths.
// - ordinary user program access stays within 0x000000 to 0x7fffff.
// - table operations reach configuration and identity only with page bit 7 set.
// - even address is lower word, odd is upper word with top byte zero.
// - instruction pointer stays even and moves in steps of two.
// - addresses below 0x000200 hold fixed reset, trap and interrupt vectors.
// - after reset execution starts at 0x000000; jump target sits at 0x000002.
// - primary vectors 0x000004-0x0000ff, alternate vectors 0x000100-0x0001ff.
// - reads and writes use separate data address generators, 16-bit data.
// - data addresses are 16-bit byte addresses over 64 Kbytes.
// - top data address bit clear selects ram, set selects program window.
// - up to 16 Kbytes of ram; reads past it in the lower half return zero.
// - low byte at even address, high byte at odd address.
// - program window is visible only with the core window enable bit set.
// - odd word access flags an address error; read completes, write suppressed.
module masd_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic fetch_advance,
  input wire logic fetch_retreat,
  input wire logic jump_load,
  input wire logic [22:0] jump_target,
  input wire logic table_read_op,
  input wire logic table_write_op,
  input wire logic [7:0] table_page_register,
  input wire logic [15:0] table_offset,
  input wire logic [15:0] table_wr_data,
  input wire logic rd_req,
  input wire logic rd_word,
  input wire logic [15:0] rd_byte_addr,
  input wire logic wr_req,
  input wire logic wr_word,
  input wire logic [15:0] wr_byte_addr,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] core_control_register,
  input wire logic [7:0] prog_window_page,
  input wire logic [15:0] ram_rd_data,
  input wire logic [23:0] flash_rd_data,
  output logic [22:0] instruction_pointer_q,
  output logic [23:0] fetch_addr_q,
  output masd_pkg::masd_region_type fetch_region_q,
  output logic ram_rd_en_q,
  output logic [12:0] ram_rd_index_q,
  output logic ram_wr_en_q,
  output logic [12:0] ram_wr_index_q,
  output logic [1:0] ram_wr_lanes_q,
  output logic [15:0] ram_wr_data_q,
  output logic flash_rd_en_q,
  output logic flash_wr_en_q,
  output logic [23:0] flash_addr_q,
  output logic [15:0] flash_wr_data_q,
  output masd_pkg::masd_region_type flash_region_q,
  output logic [15:0] rd_data_q,
  output logic rd_valid_q,
  output logic [15:0] table_data_q,
  output logic table_valid_q,
  output logic addr_error_q
);

  masd_pkg::masd_state_type s_q;
  masd_pkg::masd_state_type s_d;

  logic rd_in_ram;
  logic rd_to_win;
  logic rd_mis;
  logic [12:0] rd_index;
  logic wr_in_ram;
  logic wr_to_win;
  logic wr_mis;
  logic [12:0] wr_index;
  logic [1:0] wr_lanes;
  logic window_en;
  logic [23:0] tbl_addr;
  logic [23:0] win_addr;
  logic [22:0] ip_next;
  logic [15:0] rd_src;
  logic [15:0] tbl_src;
  masd_pkg::masd_region_type tbl_region;

  // one region map serves fetch, table and window paths
  function automatic masd_pkg::masd_region_type classify(input logic [23:0] a);
    if (a[masd_pkg::UPPER_HALF_BIT]) begin
      if ((a >= masd_pkg::CONFIG_START && a <= masd_pkg::CONFIG_END) ||
          a >= masd_pkg::IDENT_START) begin
        classify = masd_pkg::region_config;
      end else begin
        classify = masd_pkg::region_reserved;
      end
    end else if (a < masd_pkg::IVT_START) begin
      classify = masd_pkg::region_reset_vector;
    end else if (a <= masd_pkg::IVT_END) begin
      classify = masd_pkg::region_primary_vectors;
    end else if (a >= masd_pkg::ALT_IVT_START && a <= masd_pkg::ALT_IVT_END) begin
      classify = masd_pkg::region_alternate_vectors;
    end else if (a < masd_pkg::FLASH_END) begin
      classify = masd_pkg::region_user_flash;
    end else begin
      classify = masd_pkg::region_unimplemented;
    end
  endfunction

  assign window_en = core_control_register[masd_pkg::CORE_WINDOW_ENABLE_BIT];

  // separate decoders so a read and a write can resolve in the same cycle
  masd_data_decode u_rd_decode (
    .byte_addr(rd_byte_addr),
    .word_access(rd_word),
    .window_enable(window_en),
    .in_ram(rd_in_ram),
    .to_window(rd_to_win),
    .misaligned(rd_mis),
    .word_index(rd_index),
    .lanes()
  );

  masd_data_decode u_wr_decode (
    .byte_addr(wr_byte_addr),
    .word_access(wr_word),
    .window_enable(window_en),
    .in_ram(wr_in_ram),
    .to_window(wr_to_win),
    .misaligned(wr_mis),
    .word_index(wr_index),
    .lanes(wr_lanes)
  );

  always_comb begin
    s_d = s_q;
    // page bit 7 is the only way a program address gets its top bit set
    tbl_addr = {table_page_register, table_offset};
    // window address keeps the top bit clear, so it stays in user space
    win_addr = {1'b0, prog_window_page, rd_byte_addr[14:1], 1'b0};
    tbl_region = classify(tbl_addr);
    ip_next = s_q.ip;
    if (jump_load) begin
      ip_next = {jump_target[22:1], 1'b0};
    end else if (fetch_advance) begin
      ip_next = s_q.ip + masd_pkg::IP_STEP;
    end else if (fetch_retreat) begin
      ip_next = s_q.ip - masd_pkg::IP_STEP;
    end
    s_d.ip = ip_next;
    s_d.fetch_addr = {1'b0, ip_next};
    s_d.fetch_region = classify({1'b0, ip_next});

    // data read path
    s_d.ram_rd_en = rd_req && rd_in_ram;
    s_d.ram_rd_index = rd_index;
    s_d.rd_pend = rd_req;
    s_d.rd_zero = !(rd_in_ram || rd_to_win);
    s_d.rd_hi = rd_byte_addr[0];
    s_d.rd_byte = !rd_word;
    s_d.rd_win = rd_to_win;

    // data write path; the window half is read-only and drops stores
    s_d.ram_wr_en = wr_req && wr_in_ram && !wr_mis;
    s_d.ram_wr_index = wr_index;
    s_d.ram_wr_lanes = wr_lanes;
    s_d.ram_wr_data = wr_word ? wr_data : {wr_data[7:0], wr_data[7:0]};
    s_d.addr_error = (rd_req && rd_mis) || (wr_req && wr_mis);

    // flash port: a window read owns it, a table op in that cycle is dropped
    s_d.flash_rd_en = 1'b0;
    s_d.flash_wr_en = 1'b0;
    s_d.tbl_pend = 1'b0;
    s_d.tbl_hi = tbl_addr[0];
    s_d.tbl_zero = (tbl_region == masd_pkg::region_unimplemented) ||
                   (tbl_region == masd_pkg::region_reserved);
    s_d.flash_wr_data = table_wr_data;
    if (rd_req && rd_to_win) begin
      s_d.flash_rd_en = 1'b1;
      s_d.flash_addr = win_addr;
      s_d.flash_region = classify(win_addr);
    end else if (table_read_op || table_write_op) begin
      s_d.flash_addr = tbl_addr;
      s_d.flash_region = tbl_region;
      s_d.flash_rd_en = table_read_op;
      s_d.tbl_pend = table_read_op;
      s_d.flash_wr_en = table_write_op && !s_d.tbl_zero;
    end

    // return stage, one cycle after the memory strobe
    if (s_q.rd_win) begin
      rd_src = flash_rd_data[15:0];
    end else begin
      rd_src = ram_rd_data;
    end
    s_d.rd_valid = s_q.rd_pend;
    if (!s_q.rd_pend || s_q.rd_zero) begin
      s_d.rd_data = 16'h0000;
    end else if (s_q.rd_byte) begin
      s_d.rd_data = {8'h00, s_q.rd_hi ? rd_src[15:8] : rd_src[7:0]};
    end else begin
      s_d.rd_data = rd_src;
    end
    // upper word carries only 8 real bits; the top byte reads as zero
    tbl_src = s_q.tbl_hi ? {8'h00, flash_rd_data[23:16]} : flash_rd_data[15:0];
    s_d.table_valid = s_q.tbl_pend;
    s_d.table_data = (s_q.tbl_pend && !s_q.tbl_zero) ? tbl_src : 16'h0000;

    if (rst) begin
      s_d = '0;
      s_d.ip = masd_pkg::IP_RESET;
      s_d.fetch_addr = masd_pkg::RESET_VECTOR;
      s_d.fetch_region = masd_pkg::region_reset_vector;
      s_d.flash_region = masd_pkg::region_reset_vector;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end

  assign instruction_pointer_q = s_q.ip;
  assign fetch_addr_q = s_q.fetch_addr;
  assign fetch_region_q = s_q.fetch_region;
  assign ram_rd_en_q = s_q.ram_rd_en;
  assign ram_rd_index_q = s_q.ram_rd_index;
  assign ram_wr_en_q = s_q.ram_wr_en;
  assign ram_wr_index_q = s_q.ram_wr_index;
  assign ram_wr_lanes_q = s_q.ram_wr_lanes;
  assign ram_wr_data_q = s_q.ram_wr_data;
  assign flash_rd_en_q = s_q.flash_rd_en;
  assign flash_wr_en_q = s_q.flash_wr_en;
  assign flash_addr_q = s_q.flash_addr;
  assign flash_wr_data_q = s_q.flash_wr_data;
  assign flash_region_q = s_q.flash_region;
  assign rd_data_q = s_q.rd_data;
  assign rd_valid_q = s_q.rd_valid;
  assign table_data_q = s_q.table_data;
  assign table_valid_q = s_q.table_valid;
  assign addr_error_q = s_q.addr_error;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_out_of_ram_read;
    rd_req && !rd_byte_addr[15] && (rd_byte_addr > masd_pkg::RAM_TOP);
  endsequence

  sequence s_zero_return;
    !ram_rd_en_q ##1 (rd_valid_q && rd_data_q == 16'h0000);
  endsequence

  sequence s_hidden_window_read;
    rd_req && rd_byte_addr[15] && !core_control_register[2];
  endsequence

  a_reset_vector: assert property ($fell(rst) |->
    instruction_pointer_q == 23'h000000 && fetch_addr_q == 24'h000000)
    else $error("pointer not at reset vector after reset");

  a_ip_advance: assert property (fetch_advance && !jump_load |=>
    instruction_pointer_q == $past(instruction_pointer_q) + 23'h000002)
    else $error("pointer did not advance by two");

  a_ip_retreat: assert property (fetch_retreat && !fetch_advance && !jump_load |=>
    instruction_pointer_q == $past(instruction_pointer_q) - 23'h000002)
    else $error("pointer did not retreat by two");

  a_ip_even: assert property (instruction_pointer_q[0] == 1'b0)
    else $error("pointer left even alignment");

  a_fetch_user_half: assert property (fetch_addr_q[23] == 1'b0 &&
    fetch_addr_q[22:0] == instruction_pointer_q)
    else $error("fetch address outside lower half or not from pointer");

  a_config_gate: assert property (flash_rd_en_q && flash_addr_q[23] |->
    $past(table_read_op && table_page_register[7] &&
    !(rd_req && rd_byte_addr[15] && core_control_register[2])))
    else $error("upper program half reached without table page bit");

  a_table_dropped: assert property (table_read_op && rd_req && rd_byte_addr[15] &&
    core_control_register[2] |-> ##2 !table_valid_q)
    else $error("table read not dropped behind window read");

  a_vector_map: assert property (fetch_addr_q >= 24'h000004 &&
    fetch_addr_q <= 24'h0000ff |-> fetch_region_q == masd_pkg::region_primary_vectors)
    else $error("primary vector range misclassified");

  a_zero_fill: assert property (s_out_of_ram_read |=> s_zero_return)
    else $error("read outside ram did not return zero");

  a_window_hidden: assert property (s_hidden_window_read |=>
    !flash_rd_en_q ##1 (rd_data_q == 16'h0000))
    else $error("program window visible while disabled");

  a_store_blocked: assert property (wr_req && wr_word && wr_byte_addr[0] |=>
    addr_error_q && !ram_wr_en_q)
    else $error("odd word store not suppressed");

  a_byte_lane: assert property (wr_req && !wr_word && wr_byte_addr[0] &&
    wr_byte_addr <= 16'h3fff |=> ram_wr_en_q && ram_wr_lanes_q == 2'h2 &&
    ram_wr_data_q[15:8] == $past(wr_data[7:0]))
    else $error("odd byte store used wrong lane");

  a_upper_byte: assert property (table_read_op && table_offset[0] && !rd_req |->
    ##2 (table_valid_q && table_data_q[15:8] == 8'h00))
    else $error("upper word top byte not zero");

endmodule

//--- sim/masd_mem_model.sv
// ram and flash model answering the decoder's memory strobes
module masd_mem_model (
  input wire logic ref_clk,
  input wire logic ram_rd_en_q,
  input wire logic [12:0] ram_rd_index_q,
  input wire logic ram_wr_en_q,
  input wire logic [12:0] ram_wr_index_q,
  input wire logic [1:0] ram_wr_lanes_q,
  input wire logic [15:0] ram_wr_data_q,
  input wire logic flash_rd_en_q,
  input wire logic [23:0] flash_addr_q,
  output logic [15:0] ram_rd_data,
  output logic [23:0] flash_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [8192];
  logic [23:0] fpat;
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 16'h0000;
    end
  end
  always @(posedge ref_clk) begin
    if (ram_wr_en_q && ram_wr_lanes_q[0]) begin
      mem[ram_wr_index_q][7:0] <= ram_wr_data_q[7:0];
    end
    if (ram_wr_en_q && ram_wr_lanes_q[1]) begin
      mem[ram_wr_index_q][15:8] <= ram_wr_data_q[15:8];
    end
  end
  // flash pattern depends on the address so a wrong address shows
  assign fpat = {flash_addr_q[8:1] ^ 8'ha5, flash_addr_q[15:1], 1'h0} ^ 24'h001234;
  // unselected memory shows inverted data so a stale sample cannot pass
  assign ram_rd_data = ram_rd_en_q ? mem[ram_rd_index_q] : ~mem[ram_rd_index_q];
  assign flash_rd_data = flash_rd_en_q ? fpat : ~fpat;
endmodule

//--- sim/masd_top_tb.sv
// self-checking bench for the address space decoder
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module masd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [15:0] a;
    logic w;
    logic en;
    logic s;
    logic [15:0] d;
    logic e;
  } masd_row_type;
  logic ref_clk, rst, fetch_advance, fetch_retreat, jump_load;
  logic [22:0] jump_target, instruction_pointer_q;
  logic table_read_op, table_write_op, rd_req, rd_word, wr_req, wr_word;
  logic [7:0] table_page_register, prog_window_page;
  logic [15:0] table_offset, table_wr_data, rd_byte_addr, wr_byte_addr, wr_data;
  logic [15:0] core_control_register, ram_rd_data, ram_wr_data_q, flash_wr_data_q;
  logic [15:0] rd_data_q, table_data_q;
  logic [23:0] flash_rd_data, fetch_addr_q, flash_addr_q;
  logic ram_rd_en_q, ram_wr_en_q, flash_rd_en_q, flash_wr_en_q, rd_valid_q;
  logic table_valid_q, addr_error_q;
  logic [12:0] ram_rd_index_q, ram_wr_index_q;
  logic [1:0] ram_wr_lanes_q;
  masd_pkg::masd_region_type fetch_region_q, flash_region_q;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  masd_row_type rows [11] = '{
    '{16'h0010, 1'h1, 1'h0, 1'h1, 16'h1234, 1'h0}, '{16'h0010, 1'h0, 1'h0, 1'h1, 16'h0034, 1'h0},
    '{16'h0011, 1'h0, 1'h0, 1'h1, 16'h0012, 1'h0}, '{16'h0012, 1'h1, 1'h0, 1'h1, 16'hab00, 1'h0},
    '{16'h0013, 1'h0, 1'h0, 1'h1, 16'h00ab, 1'h0}, '{16'h0011, 1'h1, 1'h0, 1'h1, 16'h1234, 1'h1},
    '{16'h4000, 1'h1, 1'h0, 1'h0, 16'h0000, 1'h0}, '{16'h7fff, 1'h0, 1'h0, 1'h0, 16'h0000, 1'h0},
    '{16'h8004, 1'h1, 1'h0, 1'h0, 16'h0000, 1'h0}, '{16'h8004, 1'h1, 1'h1, 1'h1, 16'h9230, 1'h0},
    '{16'h3ffe, 1'h1, 1'h0, 1'h1, 16'h0000, 1'h0}};
  masd_top uut (
    .ref_clk(ref_clk),
    .rst(rst),
    .fetch_advance(fetch_advance),
    .fetch_retreat(fetch_retreat),
    .jump_load(jump_load),
    .jump_target(jump_target),
    .table_read_op(table_read_op),
    .table_write_op(table_write_op),
    .table_page_register(table_page_register),
    .table_offset(table_offset),
    .table_wr_data(table_wr_data),
    .rd_req(rd_req),
    .rd_word(rd_word),
    .rd_byte_addr(rd_byte_addr),
    .wr_req(wr_req),
    .wr_word(wr_word),
    .wr_byte_addr(wr_byte_addr),
    .wr_data(wr_data),
    .core_control_register(core_control_register),
    .prog_window_page(prog_window_page),
    .ram_rd_data(ram_rd_data),
    .flash_rd_data(flash_rd_data),
    .instruction_pointer_q(instruction_pointer_q),
    .fetch_addr_q(fetch_addr_q),
    .fetch_region_q(fetch_region_q),
    .ram_rd_en_q(ram_rd_en_q),
    .ram_rd_index_q(ram_rd_index_q),
    .ram_wr_en_q(ram_wr_en_q),
    .ram_wr_index_q(ram_wr_index_q),
    .ram_wr_lanes_q(ram_wr_lanes_q),
    .ram_wr_data_q(ram_wr_data_q),
    .flash_rd_en_q(flash_rd_en_q),
    .flash_wr_en_q(flash_wr_en_q),
    .flash_addr_q(flash_addr_q),
    .flash_wr_data_q(flash_wr_data_q),
    .flash_region_q(flash_region_q),
    .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q),
    .table_data_q(table_data_q),
    .table_valid_q(table_valid_q),
    .addr_error_q(addr_error_q)
  );
  masd_mem_model mem_model (
    .ref_clk(ref_clk),
    .ram_rd_en_q(ram_rd_en_q),
    .ram_rd_index_q(ram_rd_index_q),
    .ram_wr_en_q(ram_wr_en_q),
    .ram_wr_index_q(ram_wr_index_q),
    .ram_wr_lanes_q(ram_wr_lanes_q),
    .ram_wr_data_q(ram_wr_data_q),
    .flash_rd_en_q(flash_rd_en_q),
    .flash_addr_q(flash_addr_q),
    .ram_rd_data(ram_rd_data),
    .flash_rd_data(flash_rd_data)
  );
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic rd(input masd_row_type r);
    @(negedge ref_clk);
    rd_req = 1'h1;
    rd_word = r.w;
    rd_byte_addr = r.a;
    core_control_register = {13'h0000, r.en, 2'h0};
    @(negedge ref_clk);
    rd_req = 1'h0;
    `CHK("addr_error", r.e, addr_error_q)
    `CHK("rd_strobe", r.s, ram_rd_en_q | flash_rd_en_q)
    `CHK("rd_index", r.a[13:1], ram_rd_index_q)
    @(negedge ref_clk);
    `CHK("rd_data", r.d, rd_data_q)
    `CHK("rd_valid", 1'h1, rd_valid_q)
  endtask
  task automatic wr(input logic [15:0] a, input logic w, input logic [15:0] d,
                    input logic s, input logic [1:0] l, input logic e);
    @(negedge ref_clk);
    wr_req = 1'h1;
    wr_word = w;
    wr_byte_addr = a;
    wr_data = d;
    @(negedge ref_clk);
    wr_req = 1'h0;
    `CHK("wr_strobe", s, ram_wr_en_q)
    `CHK("wr_error", e, addr_error_q)
    if (s) begin
      `CHK("wr_lanes", l, ram_wr_lanes_q)
      `CHK("wr_index", a[13:1], ram_wr_index_q)
    end
  endtask
  task automatic ptr(input logic j, input logic adv, input logic ret, input logic [22:0] t,
                     input logic [22:0] ip, input masd_pkg::masd_region_type rg);
    @(negedge ref_clk);
    jump_load = j;
    fetch_advance = adv;
    fetch_retreat = ret;
    jump_target = t;
    @(negedge ref_clk);
    jump_load = 1'h0;
    fetch_advance = 1'h0;
    fetch_retreat = 1'h0;
    `CHK("pointer", ip, instruction_pointer_q)
    `CHK("fetch_addr", {1'h0, ip}, fetch_addr_q)
    `CHK("region", rg, fetch_region_q)
  endtask
  task automatic tbl(input logic wop, input logic [7:0] pg, input logic [15:0] off,
                     input logic s, input logic [15:0] d);
    @(negedge ref_clk);
    table_read_op = ~wop;
    table_write_op = wop;
    table_page_register = pg;
    table_offset = off;
    @(negedge ref_clk);
    table_read_op = 1'h0;
    table_write_op = 1'h0;
    if (wop) begin
      `CHK("tbl_wr_strobe", s, flash_wr_en_q)
      if (s) begin
        `CHK("tbl_wr_data", table_wr_data, flash_wr_data_q)
        `CHK("tbl_addr", {pg, off[15:1]}, flash_addr_q[23:1])
      end
    end else begin
      @(negedge ref_clk);
      `CHK("tbl_data", d, table_data_q)
      `CHK("tbl_valid", 1'h1, table_valid_q)
    end
  endtask
  initial begin
    {rst, fetch_advance, fetch_retreat, jump_load, table_read_op, table_write_op} = 6'h20;
    {rd_req, rd_word, wr_req, wr_word} = 4'h0;
    {jump_target, table_page_register, table_offset} = 47'h0;
    {rd_byte_addr, wr_byte_addr, wr_data, core_control_register} = 64'h0;
    table_wr_data = 16'h5a5a;
    prog_window_page = 8'h01;
    repeat (5) @(negedge ref_clk);
    rst = 1'h0;
    `CHK("rst_pointer", 23'h000000, instruction_pointer_q)
    `CHK("rst_region", masd_pkg::region_reset_vector, fetch_region_q)
    wr(16'h0010, 1'h1, 16'h1234, 1'h1, 2'h3, 1'h0);
    wr(16'h0013, 1'h0, 16'h00ab, 1'h1, 2'h2, 1'h0);
    foreach (rows[i]) begin
      rd(rows[i]);
    end
    // refused stores must leave the word intact; the low byte store to 0x0014 must land
    wr(16'h0011, 1'h1, 16'hffff, 1'h0, 2'h3, 1'h1);
    wr(16'h8000, 1'h1, 16'hffff, 1'h0, 2'h3, 1'h0);
    wr(16'h4000, 1'h1, 16'hffff, 1'h0, 2'h3, 1'h0);
    wr(16'h0014, 1'h0, 16'h00cd, 1'h1, 2'h1, 1'h0);
    rd(rows[0]);
    rd('{16'h0014, 1'h1, 1'h0, 1'h1, 16'h00cd, 1'h0});
    ptr(1'h0, 1'h1, 1'h0, 23'h0, 23'h000002, masd_pkg::region_reset_vector);
    ptr(1'h0, 1'h0, 1'h1, 23'h0, 23'h000000, masd_pkg::region_reset_vector);
    ptr(1'h1, 1'h0, 1'h0, 23'h000010, 23'h000010, masd_pkg::region_primary_vectors);
    ptr(1'h1, 1'h1, 1'h0, 23'h000105, 23'h000104, masd_pkg::region_alternate_vectors);
    ptr(1'h0, 1'h1, 1'h1, 23'h0, 23'h000106, masd_pkg::region_alternate_vectors);
    ptr(1'h1, 1'h0, 1'h0, 23'h000200, 23'h000200, masd_pkg::region_user_flash);
    ptr(1'h1, 1'h0, 1'h0, 23'h02ac00, 23'h02ac00, masd_pkg::region_unimplemented);
    ptr(1'h1, 1'h0, 1'h0, 23'h7ffffe, 23'h7ffffe, masd_pkg::region_unimplemented);
    ptr(1'h0, 1'h1, 1'h0, 23'h0, 23'h000000, masd_pkg::region_reset_vector);
    tbl(1'h0, 8'h00, 16'h0100, 1'h1, 16'h1334);
    tbl(1'h0, 8'h00, 16'h0101, 1'h1, 16'h0025);
    tbl(1'h0, 8'hf8, 16'h0000, 1'h1, 16'h1234);
    `CHK("tbl_region", masd_pkg::region_config, flash_region_q)
    tbl(1'h0, 8'hff, 16'h0000, 1'h1, 16'h1234);
    tbl(1'h0, 8'h80, 16'h0000, 1'h1, 16'h0000);
    tbl(1'h0, 8'h02, 16'hac00, 1'h1, 16'h0000);
    tbl(1'h1, 8'h00, 16'h0400, 1'h1, 16'h0000);
    `CHK("wr_region", masd_pkg::region_user_flash, flash_region_q)
    tbl(1'h1, 8'h80, 16'h0000, 1'h0, 16'h0000);
    // a window read owns the flash port, so the table read beside it is dropped
    @(negedge ref_clk);
    {rd_req, rd_word, rd_byte_addr, core_control_register} = {2'h3, 16'h8004, 16'h0004};
    {table_read_op, table_page_register, table_offset} = {1'h1, 8'h00, 16'h0100};
    @(negedge ref_clk);
    {rd_req, table_read_op} = 2'h0;
    `CHK("col_addr", 24'h008004, flash_addr_q)
    @(negedge ref_clk);
    `CHK("col_tbl_valid", 1'h0, table_valid_q)
    `CHK("col_rd_data", 16'h9230, rd_data_q)
    ptr(1'h1, 1'h0, 1'h0, 23'h000300, 23'h000300, masd_pkg::region_user_flash);
    // a second reset in mid-run must return to the reset vector
    rst = 1'h1;
    @(negedge ref_clk);
    rst = 1'h0;
    `CHK("rerst_pointer", 23'h000000, instruction_pointer_q)
    `CHK("rerst_fetch", 24'h000000, fetch_addr_q)
    @(negedge ref_clk);
    `CHK("rerst_region", masd_pkg::region_reset_vector, fetch_region_q)
    tally_and_finish();
  end
endmodule
